// File: sto_gate.sv
// Safe torque off gate: input filters, cutoff path, alarms, diagnostics, register slave
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module sto_gate #(
    parameter int unsigned NUM_PWM  = 6,
    parameter int unsigned FILT_CYC = sto_pkg::FILT_CYC,
    parameter int unsigned DISC_CYC = sto_pkg::DISC_CYC,
    parameter int unsigned DIAG_CYC = sto_pkg::DIAG_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire sto_pkg::sto_axil_req_t axil_req,
    output sto_pkg::sto_axil_rsp_t     axil_rsp,
    input  wire logic                  safety_input_one,
    input  wire logic                  safety_input_two,
    input  wire logic [NUM_PWM-1:0]    pwm_in,
    input  wire logic [NUM_PWM-1:0]    cutoff_readback,
    output logic      [NUM_PWM-1:0]    pwm_out,
    output logic                       fault_monitor_output,
    output logic                       input_disconnect_alarm,
    output logic                       cutoff_circuit_failure_alarm,
    output logic                       safe_state
);
    localparam int unsigned FW = $clog2(FILT_CYC + 1);
    localparam int unsigned DW = $clog2(DISC_CYC + 1);
    localparam int unsigned GW = $clog2(DIAG_CYC + 1);

    // *******************************
    // Input synchronisers and filters
    // *******************************
    logic [1:0]  in_meta_q;
    logic [1:0]  in_sync_q;
    logic [1:0]  off_q;
    logic [FW-1:0] low_cnt_q [2];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_meta_q <= 2'h0;
            in_sync_q <= 2'h0;
        end else begin
            in_meta_q <= {safety_input_two, safety_input_one};
            in_sync_q <= in_meta_q;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                low_cnt_q[i] <= '0;
                off_q[i]     <= 1'b1;
            end else if (in_sync_q[i]) begin
                low_cnt_q[i] <= '0;
                off_q[i]     <= 1'b0;
            end else if (low_cnt_q[i] == FW'(FILT_CYC)) begin
                off_q[i]     <= 1'b1;
            end else begin
                low_cnt_q[i] <= low_cnt_q[i] + FW'(1);
            end
        end
    end

    wire any_off  = |off_q;
    wire both_off = &off_q;
    wire both_on  = ~any_off;

    // *********************
    // Registers set by bus
    // *********************
    logic stop_q;
    logic clr_disc_q;
    logic clr_fail_q;

    // ***************
    // Gate state flow
    // ***************
    sto_pkg::sto_state_t state_q;
    logic fail_q;
    logic disc_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= sto_pkg::ST_SAFE;
        end else begin
            case (state_q)
                sto_pkg::ST_RUN: begin
                    if (fail_q) state_q <= sto_pkg::ST_FAULT;
                    else if (any_off || stop_q) state_q <= sto_pkg::ST_SAFE;
                end
                sto_pkg::ST_SAFE: begin
                    if (fail_q) state_q <= sto_pkg::ST_FAULT;
                    else if (both_on && !stop_q) state_q <= sto_pkg::ST_RUN;
                end
                sto_pkg::ST_FAULT: begin
                    if (!fail_q) state_q <= sto_pkg::ST_SAFE;
                end
                default: state_q <= sto_pkg::ST_SAFE;
            endcase
        end
    end

    wire gate_open = (state_q == sto_pkg::ST_RUN);

    // ***********
    // Cutoff path
    // ***********
    logic [NUM_PWM-1:0] pwm_q;
    logic               edm_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_q <= '0;
        end else begin
            pwm_q <= gate_open ? pwm_in : '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            edm_q <= 1'b0;
        end else begin
            edm_q <= both_off;
        end
    end

    assign pwm_out              = pwm_q;
    assign fault_monitor_output = edm_q;
    assign safe_state           = ~gate_open;

    // *****************
    // Disconnect alarm
    // *****************
    logic [DW-1:0] disc_cnt_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            disc_cnt_q <= '0;
        end else if (!any_off) begin
            disc_cnt_q <= '0;
        end else if (disc_cnt_q != DW'(DISC_CYC)) begin
            disc_cnt_q <= disc_cnt_q + DW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            disc_q <= 1'b0;
        end else if (any_off && disc_cnt_q == DW'(DISC_CYC)) begin
            disc_q <= 1'b1;
        end else if (clr_disc_q) begin
            disc_q <= 1'b0;
        end
    end

    // *************************
    // Cutoff circuit diagnostic
    // *************************
    logic [NUM_PWM-1:0] rb_meta_q;
    logic [NUM_PWM-1:0] rb_sync_q;
    logic [GW-1:0]      diag_cnt_q;
    logic               closed_q;
    logic [15:0]        diag_runs_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rb_meta_q <= '0;
            rb_sync_q <= '0;
        end else begin
            rb_meta_q <= cutoff_readback;
            rb_sync_q <= rb_meta_q;
        end
    end

    wire diag_tick = (diag_cnt_q == GW'(DIAG_CYC - 1));
    wire diag_bad  = diag_tick && closed_q && !gate_open && (|rb_sync_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            diag_cnt_q  <= '0;
            closed_q    <= 1'b0;
            diag_runs_q <= 16'h0000;
        end else if (diag_tick) begin
            diag_cnt_q  <= '0;
            closed_q    <= !gate_open;
            diag_runs_q <= diag_runs_q + 16'h0001;
        end else begin
            diag_cnt_q  <= diag_cnt_q + GW'(1);
            if (gate_open) closed_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fail_q <= 1'b0;
        end else if (diag_bad) begin
            fail_q <= 1'b1;
        end else if (clr_fail_q) begin
            fail_q <= 1'b0;
        end
    end

    assign input_disconnect_alarm       = disc_q;
    assign cutoff_circuit_failure_alarm = fail_q;

    // *******************
    // AXI4-Lite slave
    // *******************
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [7:0]        aw_addr_q;
    logic [31:0]       w_data_q;
    logic              w_strb0_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic [31:0]       stat_w;

    wire awready = !aw_hold_q && !bvalid_q;
    wire wready  = !w_hold_q && !bvalid_q;
    wire arready = !rvalid_q;
    wire wr_go   = aw_hold_q && w_hold_q;
    wire wr_ctrl = wr_go && (aw_addr_q == sto_pkg::REG_CTRL) && w_strb0_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (axil_req.awvalid && awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= axil_req.awaddr;
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w_hold_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb0_q <= 1'b0;
        end else if (axil_req.wvalid && wready) begin
            w_hold_q  <= 1'b1;
            w_data_q  <= axil_req.wdata;
            w_strb0_q <= axil_req.wstrb[0];
        end else if (wr_go) begin
            w_hold_q  <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= sto_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_addr_q == sto_pkg::REG_CTRL || aw_addr_q == sto_pkg::REG_STAT
                        || aw_addr_q == sto_pkg::REG_DIAG) ? sto_pkg::RESP_OKAY
                                                           : sto_pkg::RESP_SLVERR;
        end else if (axil_req.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stop_q     <= 1'b0;
            clr_disc_q <= 1'b0;
            clr_fail_q <= 1'b0;
        end else begin
            clr_disc_q <= wr_ctrl && w_data_q[sto_pkg::CTRL_CLR_DISC];
            clr_fail_q <= wr_ctrl && w_data_q[sto_pkg::CTRL_CLR_FAIL];
            if (wr_ctrl) stop_q <= w_data_q[sto_pkg::CTRL_STOP];
        end
    end

    always_comb begin
        stat_w                     = 32'h0000_0000;
        stat_w[sto_pkg::STAT_IN1]  = ~off_q[0];
        stat_w[sto_pkg::STAT_IN2]  = ~off_q[1];
        stat_w[sto_pkg::STAT_SAFE] = ~gate_open;
        stat_w[sto_pkg::STAT_EDM]  = edm_q;
        stat_w[sto_pkg::STAT_DISC] = disc_q;
        stat_w[sto_pkg::STAT_FAIL] = fail_q;
        stat_w[sto_pkg::STAT_STOP] = stop_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= sto_pkg::RESP_OKAY;
        end else if (axil_req.arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= sto_pkg::RESP_OKAY;
            case (axil_req.araddr)
                sto_pkg::REG_CTRL: rdata_q <= {31'h0000_0000, stop_q};
                sto_pkg::REG_STAT: rdata_q <= stat_w;
                sto_pkg::REG_DIAG: rdata_q <= {16'h0000, diag_runs_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= sto_pkg::RESP_SLVERR;
                end
            endcase
        end else if (axil_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign axil_rsp.awready = awready;
    assign axil_rsp.wready  = wready;
    assign axil_rsp.bvalid  = bvalid_q;
    assign axil_rsp.bresp   = bresp_q;
    assign axil_rsp.arready = arready;
    assign axil_rsp.rvalid  = rvalid_q;
    assign axil_rsp.rdata   = rdata_q;
    assign axil_rsp.rresp   = rresp_q;

    // **********
    // Assertions
    // **********
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [31:0] resp_cnt_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) resp_cnt_q <= '0;
        else if ((&in_sync_q) || pwm_q == '0) resp_cnt_q <= '0;
        else resp_cnt_q <= resp_cnt_q + 32'h0000_0001;
    end

    AST_PASS_OPEN: assert property (gate_open |=> pwm_q == $past(pwm_in))
        else $error("PWM not passed while gate open");
    AST_BLOCK_OFF: assert property (any_off |=> ##1 pwm_q == '0)
        else $error("PWM not blocked after input off");
    AST_ALL_LOW: assert property (!gate_open |=> pwm_q == '0)
        else $error("PWM output left high in safe state");
    AST_RESP_TIME: assert property (resp_cnt_q <= sto_pkg::RESP_CYC)
        else $error("STO response exceeded limit");
    AST_FILT_LOW: assert property ($rose(off_q[0]) |-> $past(low_cnt_q[0]) == FW'(FILT_CYC)
                                   && $past(!in_sync_q[0], 2))
        else $error("Input filtered off too early");
    AST_PULSE_REJ: assert property (in_sync_q[1] |=> !off_q[1])
        else $error("High input still seen as off");
    AST_DISC_SET: assert property ($rose(disc_q) |-> $past(disc_cnt_q) == DW'(DISC_CYC))
        else $error("Disconnect alarm raised early");
    AST_FAIL_SET: assert property (diag_bad |=> fail_q ##1 state_q == sto_pkg::ST_FAULT)
        else $error("Failure not latched into fault state");
    AST_FAULT_SAFE: assert property (fail_q |=> !gate_open)
        else $error("Fault did not force safe state");
    AST_DIAG_PERIOD: assert property (diag_cnt_q < GW'(DIAG_CYC))
        else $error("Diagnostic interval overrun");
    AST_EDM_BOTH: assert property (!$past(rst) |-> edm_q == $past(both_off))
        else $error("Fault monitor output mismatch");
    AST_EXIT_BOTH: assert property ($fell(!gate_open) |-> $past(both_on) && !$past(stop_q))
        else $error("Safe state left without both inputs on");
endmodule : sto_gate

// File: sto_pkg.sv
// Constants, register map and carrier types of the safe torque off gate
package sto_pkg;
    // ****************
    // Clock and timing
    // ****************
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned FILT_TIME_US = 2000;
    localparam int unsigned FILT_CYC     = (CLK_HZ / 1_000_000) * FILT_TIME_US;
    localparam int unsigned DISC_TIME_S  = 10;
    localparam int unsigned DISC_CYC     = CLK_HZ * DISC_TIME_S;
    localparam int unsigned DIAG_TIME_MS = 10;
    localparam int unsigned DIAG_CYC     = (CLK_HZ / 1000) * DIAG_TIME_MS;
    localparam int unsigned RESP_TIME_MS = 30;
    localparam int unsigned RESP_CYC     = (CLK_HZ / 1000) * RESP_TIME_MS;
    localparam int unsigned EDM_TIME_MS  = 5;
    localparam int unsigned EDM_CYC      = (CLK_HZ / 1000) * EDM_TIME_MS;

    // ************
    // Register map
    // ************
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0]  REG_CTRL = 8'h00;
    localparam logic [7:0]  REG_STAT = 8'h04;
    localparam logic [7:0]  REG_DIAG = 8'h08;
    localparam int unsigned CTRL_STOP     = 0;
    localparam int unsigned CTRL_CLR_DISC = 1;
    localparam int unsigned CTRL_CLR_FAIL = 2;
    localparam int unsigned STAT_IN1  = 0;
    localparam int unsigned STAT_IN2  = 1;
    localparam int unsigned STAT_SAFE = 2;
    localparam int unsigned STAT_EDM  = 3;
    localparam int unsigned STAT_DISC = 4;
    localparam int unsigned STAT_FAIL = 5;
    localparam int unsigned STAT_STOP = 6;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // *****
    // Types
    // *****
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SAFE  = 2'b01,
        ST_FAULT = 2'b10
    } sto_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } sto_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sto_axil_rsp_t;
endpackage : sto_pkg

// File: sto_safety_source.sv
// Behavioural model of the external safety source driving both safety inputs
`timescale 1ns/100ps
module sto_safety_source #(
    parameter int unsigned MAX_PULSE = 19
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        want_one,
    input  wire logic        want_two,
    input  wire logic        pulse_start,
    input  wire logic [15:0] pulse_cycles,
    output logic             safety_input_one,
    output logic             safety_input_two
);
    logic [15:0] pulse_q;

    // Self test low pulse on channel one, clamped below the filter time
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_q <= 16'h0000;
        end else if (pulse_start) begin
            pulse_q <= (pulse_cycles > 16'(MAX_PULSE)) ? 16'(MAX_PULSE) : pulse_cycles;
        end else if (pulse_q != 16'h0000) begin
            pulse_q <= pulse_q - 16'h0001;
        end
    end

    assign safety_input_one = want_one && (pulse_q == 16'h0000);
    assign safety_input_two = want_two;
endmodule : sto_safety_source

// File: tb_safe_torque_off_gate.sv
// Self-checking testbench of the safe torque off gate
`timescale 1ns/100ps
module tb_safe_torque_off_gate;
    localparam int unsigned FILT = 20;
    localparam int unsigned DISC = 200;
    localparam int unsigned DIAG = 50;
    logic                   ref_clk = 1'b0;
    logic                   rst = 1'b1;
    sto_pkg::sto_axil_req_t axil_req = '0;
    sto_pkg::sto_axil_rsp_t axil_rsp;
    logic                   want_one = 1'b1;
    logic                   want_two = 1'b1;
    logic                   pulse_start = 1'b0;
    logic [15:0]            pulse_cycles = 16'h0000;
    logic                   in_one;
    logic                   in_two;
    logic [5:0]             pwm_in = 6'h2A;
    logic [5:0]             readback = 6'h00;
    logic [5:0]             pwm_out;
    logic                   monitor;
    logic                   disc_alarm;
    logic                   fail_alarm;
    logic                   safe_state;
    int                     fail_count = 0;
    int                     check_count = 0;
    int                     cycles = 0;
    logic [31:0]            rd;
    logic [31:0]            rd0;

    sto_gate #(.NUM_PWM(6), .FILT_CYC(FILT), .DISC_CYC(DISC), .DIAG_CYC(DIAG)) sto_gate_i (
        .ref_clk(ref_clk), .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
        .safety_input_one(in_one), .safety_input_two(in_two), .pwm_in(pwm_in),
        .cutoff_readback(readback), .pwm_out(pwm_out), .fault_monitor_output(monitor),
        .input_disconnect_alarm(disc_alarm), .cutoff_circuit_failure_alarm(fail_alarm),
        .safe_state(safe_state));

    sto_safety_source #(.MAX_PULSE(FILT - 1)) sto_safety_source_i (
        .ref_clk(ref_clk), .rst(rst), .want_one(want_one), .want_two(want_two),
        .pulse_start(pulse_start), .pulse_cycles(pulse_cycles),
        .safety_input_one(in_one), .safety_input_two(in_two));

    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    // *************
    // Check helpers
    // *************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic logic sig(input int sel);
        case (sel)
            0:       return safe_state;
            1:       return monitor;
            2:       return disc_alarm;
            default: return fail_alarm;
        endcase
    endfunction : sig

    task automatic wait_for(input int sel, input logic exp, input int max, input string name);
        int n;
        n = 0;
        while (sig(sel) !== exp && n < max) begin
            @(posedge ref_clk);
            n++;
        end
        chk(name, {31'h0, exp}, {31'h0, sig(sel)});
    endtask : wait_for

    task automatic hold(input int sel, input logic exp, input int n, input string name);
        logic seen;
        seen = exp;
        repeat (n) begin
            @(posedge ref_clk);
            if (sig(sel) !== exp) seen = sig(sel);
        end
        chk(name, {31'h0, exp}, {31'h0, seen});
    endtask : hold

    // ***************
    // Register access
    // ***************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        @(posedge ref_clk);
        axil_req.awvalid <= 1'b1;
        axil_req.awaddr  <= a;
        axil_req.wvalid  <= 1'b1;
        axil_req.wdata   <= d;
        axil_req.wstrb   <= s;
        axil_req.bready  <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (axil_req.awvalid && axil_rsp.awready) axil_req.awvalid <= 1'b0;
            if (axil_req.wvalid && axil_rsp.wready) axil_req.wvalid <= 1'b0;
            if (axil_rsp.bvalid) begin
                axil_req.bready <= 1'b0;
                break;
            end
        end
        chk("bvalid", 32'h1, {31'h0, axil_rsp.bvalid});
        chk("bresp", {30'h0, er}, {30'h0, axil_rsp.bresp});
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        d = 'x;
        r = 'x;
        @(posedge ref_clk);
        axil_req.arvalid <= 1'b1;
        axil_req.araddr  <= a;
        axil_req.rready  <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (axil_req.arvalid && axil_rsp.arready) axil_req.arvalid <= 1'b0;
            if (axil_rsp.rvalid) begin
                d = axil_rsp.rdata;
                r = axil_rsp.rresp;
                axil_req.rready <= 1'b0;
                break;
            end
        end
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : axi_read

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // *********
    // Sequence
    // *********
    initial begin
        repeat (5) @(posedge ref_clk);
        chk("reset outputs", 32'h1, {25'h0, pwm_out, safe_state | disc_alarm | fail_alarm});
        @(posedge ref_clk);
        rst <= 1'b0;
        wait_for(0, 1'b0, 20, "gate open");
        repeat (2) @(posedge ref_clk);
        chk("pwm pass", {26'h0, pwm_in}, {26'h0, pwm_out});
        chk("monitor run", 32'h0, {31'h0, monitor});
        axi_read(sto_pkg::REG_STAT, rd, sto_pkg::RESP_OKAY);
        chk("status run", 32'h03, rd);
        $display("test open done");
        pulse_cycles <= 16'(FILT / 2);
        pulse_start  <= 1'b1;
        @(posedge ref_clk);
        pulse_start <= 1'b0;
        hold(0, 1'b0, 3 * FILT, "safe on pulse");
        $display("test pulse done");
        pwm_in <= 6'h3F;
        for (int ch = 0; ch < 2; ch++) begin
            if (ch == 0) want_one <= 1'b0;
            else want_two <= 1'b0;
            hold(0, 1'b0, FILT, "safe early");
            wait_for(0, 1'b1, 15, "safe entered");
            repeat (2) @(posedge ref_clk);
            chk("pwm blocked", 32'h0, {26'h0, pwm_out});
            chk("monitor one off", 32'h0, {31'h0, monitor});
            want_one <= 1'b1;
            want_two <= 1'b1;
            wait_for(0, 1'b0, 15, "safe left");
        end
        $display("test single off done");
        want_one <= 1'b0;
        want_two <= 1'b0;
        wait_for(1, 1'b1, FILT + 10, "monitor on");
        hold(2, 1'b0, DISC - 5, "disc early");
        wait_for(2, 1'b1, 20, "disc alarm");
        axi_read(sto_pkg::REG_STAT, rd, sto_pkg::RESP_OKAY);
        chk("status off", 32'h1C, rd);
        want_one <= 1'b1;
        hold(0, 1'b1, 40, "safe one on");
        chk("monitor half", 32'h0, {31'h0, monitor});
        want_two <= 1'b1;
        wait_for(0, 1'b0, 15, "safe left both");
        axi_write(sto_pkg::REG_CTRL, 32'h2, 4'hF, sto_pkg::RESP_OKAY);
        wait_for(2, 1'b0, 3, "disc clear");
        $display("test both off done");
        axi_write(sto_pkg::REG_CTRL, 32'h1, 4'hF, sto_pkg::RESP_OKAY);
        wait_for(0, 1'b1, 5, "stop safe");
        axi_write(sto_pkg::REG_CTRL, 32'h0, 4'h0, sto_pkg::RESP_OKAY);
        hold(0, 1'b1, 10, "stop kept");
        axi_read(sto_pkg::REG_CTRL, rd, sto_pkg::RESP_OKAY);
        chk("ctrl", 32'h1, rd);
        $display("test stop done");
        readback <= 6'h01;
        wait_for(3, 1'b1, 2 * DIAG + 10, "fail alarm");
        chk("fault gate", 32'h1, {25'h0, pwm_out, safe_state});
        axi_read(sto_pkg::REG_DIAG, rd0, sto_pkg::RESP_OKAY);
        // Three cycles of read overhead make the two samples exactly ten intervals apart
        repeat (10 * DIAG - 3) @(posedge ref_clk);
        axi_read(sto_pkg::REG_DIAG, rd, sto_pkg::RESP_OKAY);
        chk("diag ticks", 32'h0A, rd - rd0);
        readback <= 6'h00;
        axi_write(sto_pkg::REG_CTRL, 32'h4, 4'hF, sto_pkg::RESP_OKAY);
        wait_for(3, 1'b0, 5, "fail clear");
        wait_for(0, 1'b0, 15, "run again");
        $display("test diag done");
        axi_read(8'h0C, rd, sto_pkg::RESP_SLVERR);
        chk("unmapped", 32'h0, rd);
        axi_write(8'h0C, 32'h1, 4'hF, sto_pkg::RESP_SLVERR);
        axi_write(sto_pkg::REG_STAT, 32'hFF, 4'hF, sto_pkg::RESP_OKAY);
        axi_read(sto_pkg::REG_STAT, rd, sto_pkg::RESP_OKAY);
        chk("status ro", 32'h03, rd);
        $display("test map done");
        complete_run();
    end
endmodule : tb_safe_torque_off_gate
